/* pkg/rsq_params.svh */
// Purpose: timing constants for the reset start-up delay sequencer
// Assumes: 250 MHz clock
// Notes:   times in ns, cycle counts derived by round-up
`ifndef RSQ_PARAMS_SVH
`define RSQ_PARAMS_SVH
`define RSQ_CLK_PERIOD_NS      4
`define RSQ_T_POR_NS           10000
`define RSQ_T_STARTUP_REG_NS   20000
`define RSQ_T_POWER_UP_TIMER_NS          64000000
`define RSQ_T_RST_NS           20000
`define RSQ_T_LOCK_NS          20000
`define RSQ_T_FAIL_SAFE_CLOCK_MONITOR_NS          100000
`define RSQ_CYC(t)             (((t) + `RSQ_CLK_PERIOD_NS - 1) / `RSQ_CLK_PERIOD_NS)
`define RSQ_OST_PERIODS        1024
`define RSQ_OST_WIDTH          10
`define RSQ_CNT_WIDTH          25
`endif

/* pkg/rsq_pkg.sv */
// Purpose: types for the reset start-up delay sequencer
// Assumes: nothing
// Notes:   reset cause and clock source encodings
package rsq_pkg;
    typedef enum logic [2:0] {
        RSQ_CAUSE_POR   = 3'h0,
        RSQ_CAUSE_BOR   = 3'h1,
        RSQ_CAUSE_OTHER = 3'h2,
        RSQ_CAUSE_WAKE  = 3'h3
    } rsq_cause_e;
    typedef enum logic [2:0] {
        RSQ_SRC_PLAIN   = 3'h0,
        RSQ_SRC_PLL     = 3'h1,
        RSQ_SRC_XTAL    = 3'h2,
        RSQ_SRC_XTALPLL = 3'h3
    } rsq_src_e;
    typedef enum logic [3:0] {
        RSQ_ST_IDLE    = 4'h0,
        RSQ_ST_POR     = 4'h1,
        RSQ_ST_STARTUP = 4'h2,
        RSQ_ST_RST     = 4'h3,
        RSQ_ST_RUN     = 4'h4
    } rsq_state_e;
    typedef enum logic [2:0] {
        RSQ_CK_IDLE = 3'h0,
        RSQ_CK_OST  = 3'h1,
        RSQ_CK_LOCK = 3'h2,
        RSQ_CK_FAIL_SAFE_CLOCK_MONITOR = 3'h3,
        RSQ_CK_DONE = 3'h4
    } rsq_ck_e;
    typedef struct packed {
        logic       req;
        rsq_cause_e cause;
        rsq_src_e   src;
        logic       reg_en;
    } rsq_req_s;
endpackage : rsq_pkg

/* logic/rsq_sequencer.sv */
// Purpose: release internal system reset and system clock after each reset type
// Assumes: inputs synchronous to clk_i; osc_tick_i one pulse per oscillator period
// Notes:   registers reached over a plain strobe port
//
// Notes on behaviour
// [RULE_01] power-on: hold reset for power-on, start-up and internal state times
// [RULE_02] power-on delay is ten microseconds
// [RULE_03] start-up is 20 us with regulator on, 64 ms power-up timer otherwise
// [RULE_04] wake from powered-down state applies start-up only with regulator on
// [RULE_05] internal state reset time is 20 us, ends every sequence
// [RULE_06] brown-out: start-up plus internal state time, no power-on delay
// [RULE_07] other resets: only internal state time, no clock or monitor delays
// [RULE_08] power-on/brown-out: oscillator start-up for crystal, lock for PLL, both for both
// [RULE_09] oscillator start-up counts 1024 oscillator periods with a 10-bit counter
// [RULE_10] PLL lock delay is 20 us
// [RULE_11] clock delays run independently of the reset delays
// [RULE_12] no execution until a valid clock is released
// [RULE_13] enabled monitor starts supervising at internal reset release
// [RULE_14] no valid clock at monitor start switches to fast internal RC
// [RULE_15] crystal or PLL sources add a monitor delay before supervision
// [RULE_16] monitor delay is a parameter, default 100 us
// [RULE_17] each delay is a counter from a scaled parameter, run in sequence; oscillator start-up compares against a fixed 10'h3ff, not a parameter
// [RULE_18] reset cause and clock source latched at reset entry
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "rsq_params.svh"

module rsq_sequencer
    import rsq_pkg::*;
#(
    parameter int T_POR_NS     = `RSQ_T_POR_NS,
    parameter int T_STARTUP_NS = `RSQ_T_STARTUP_REG_NS,
    parameter int T_POWER_UP_TIMER_NS    = `RSQ_T_POWER_UP_TIMER_NS,
    parameter int T_RST_NS     = `RSQ_T_RST_NS,
    parameter int T_LOCK_NS    = `RSQ_T_LOCK_NS,
    parameter int T_FAIL_SAFE_CLOCK_MONITOR_NS    = `RSQ_T_FAIL_SAFE_CLOCK_MONITOR_NS
)(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    input  wire rsq_req_s   rst_req_i,
    input  wire logic       osc_tick_i,
    input  wire logic       fail_safe_clock_monitor_en_i,
    input  wire logic       clk_valid_i,
    input  wire logic [3:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    output logic            sys_rst_o,
    output logic            sys_clk_en_o,
    output logic            exec_en_o,
    output logic            fail_safe_clock_monitor_active_o,
    output logic            frc_switch_o,
    output logic            irq_o
);
    localparam logic [24:0] C_POR  = 25'(`RSQ_CYC(T_POR_NS));     // [RULE_02]
    localparam logic [24:0] C_STRT = 25'(`RSQ_CYC(T_STARTUP_NS)); // [RULE_03]
    localparam logic [24:0] C_POWER_UP_TIMER = 25'(`RSQ_CYC(T_POWER_UP_TIMER_NS));    // [RULE_03]
    localparam logic [24:0] C_RST  = 25'(`RSQ_CYC(T_RST_NS));     // [RULE_05]
    localparam logic [24:0] C_LOCK = 25'(`RSQ_CYC(T_LOCK_NS));    // [RULE_10]
    localparam logic [24:0] C_FAIL_SAFE_CLOCK_MONITOR = 25'(`RSQ_CYC(T_FAIL_SAFE_CLOCK_MONITOR_NS));    // [RULE_16]
    localparam logic [3:0]  A_STAT = 4'h0;
    localparam logic [3:0]  A_MASK = 4'h1;
    localparam logic [3:0]  A_INFO = 4'h2;

    // ==========================================================
    // latched request
    rsq_cause_e  cause_reg;
    rsq_src_e    src_reg;
    logic        regen_reg;
    rsq_state_e  st_reg;
    rsq_state_e  st_next;
    logic [24:0] cnt_reg;
    logic [24:0] cnt_next;
    rsq_ck_e     ck_reg;
    rsq_ck_e     ck_next;
    logic [24:0] ckc_reg;
    logic [24:0] ckc_next;
    logic [9:0]  ost_reg;
    logic        frc_reg;
    logic        mon_reg;
    logic [2:0]  stat_reg;
    logic [2:0]  mask_reg;
    logic [7:0]  rdata_reg;

    wire req       = ce_i && rst_req_i.req;
    wire cnt_done  = (cnt_reg == 25'h0000001);
    wire ckc_done  = (ckc_reg == 25'h0000001);
    wire is_pwr    = (cause_reg == RSQ_CAUSE_POR) || (cause_reg == RSQ_CAUSE_BOR);
    wire use_xtal  = is_pwr && src_reg[1];                          // [RULE_08]
    wire use_pll   = is_pwr && src_reg[0];                          // [RULE_08]
    wire use_fail_safe_clock_monitor  = is_pwr && (src_reg != RSQ_SRC_PLAIN);          // [RULE_15]
    wire rst_rel   = (st_reg == RSQ_ST_RST) && cnt_done;
    wire clk_rdy   = (ck_reg == RSQ_CK_DONE) || (ck_reg == RSQ_CK_FAIL_SAFE_CLOCK_MONITOR);
    wire clk_rdy_fail_safe_clock_monitor = (ck_reg == RSQ_CK_DONE);
    wire mon_start = clk_rdy_fail_safe_clock_monitor && fail_safe_clock_monitor_en_i && (st_reg == RSQ_ST_RUN) && !mon_reg;
    wire fail_ev   = mon_start && !clk_valid_i;                     // [RULE_14]
    wire [2:0] ev  = {fail_ev, 1'b0, rst_rel};
    wire wr_stat   = wr_i && (addr_i == A_STAT);
    wire wr_mask   = wr_i && (addr_i == A_MASK);
    wire [7:0] rd_mux = (addr_i == A_STAT) ? {5'h00, stat_reg} :
                        (addr_i == A_MASK) ? {5'h00, mask_reg} :
                        (addr_i == A_INFO) ? {st_reg[2:0], ck_reg, frc_reg, mon_reg} :
                        8'h00;

    // ==========================================================
    // reset delay chain
    always_comb
    begin
        st_next  = st_reg;
        cnt_next = (cnt_reg > 25'h0000001) ? cnt_reg - 25'h0000001 : cnt_reg;
        case (st_reg)
            RSQ_ST_POR:     if (cnt_done)
                            begin
                                st_next  = RSQ_ST_STARTUP;                    // [RULE_17]
                                cnt_next = regen_reg ? C_STRT : C_POWER_UP_TIMER;       // [RULE_03]
                            end
            RSQ_ST_STARTUP: if (cnt_done)
                            begin
                                st_next  = RSQ_ST_RST;
                                cnt_next = C_RST;                             // [RULE_05]
                            end
            RSQ_ST_RST:     if (cnt_done)
                                st_next = RSQ_ST_RUN;
            RSQ_ST_RUN:     st_next = RSQ_ST_RUN;
            RSQ_ST_IDLE:    st_next = RSQ_ST_IDLE;
            default:        st_next = RSQ_ST_IDLE;
        endcase
        if (req)
        begin
            case (rst_req_i.cause)
                RSQ_CAUSE_POR:
                begin
                    st_next  = RSQ_ST_POR;                                    // [RULE_01]
                    cnt_next = C_POR;
                end
                RSQ_CAUSE_BOR:
                begin
                    st_next  = RSQ_ST_STARTUP;                                // [RULE_06]
                    cnt_next = rst_req_i.reg_en ? C_STRT : C_POWER_UP_TIMER;
                end
                RSQ_CAUSE_WAKE:
                begin
                    st_next  = rst_req_i.reg_en ? RSQ_ST_STARTUP : RSQ_ST_RST; // [RULE_04]
                    cnt_next = rst_req_i.reg_en ? C_STRT : C_RST;
                end
                default:
                begin
                    st_next  = RSQ_ST_RST;                                    // [RULE_07]
                    cnt_next = C_RST;
                end
            endcase
        end
    end

    // ==========================================================
    // clock release chain, independent of the reset chain
    always_comb
    begin
        ck_next  = ck_reg;
        ckc_next = (ckc_reg > 25'h0000001) ? ckc_reg - 25'h0000001 : ckc_reg;
        case (ck_reg)
            RSQ_CK_IDLE:
            begin
                if (use_xtal)
                    ck_next = RSQ_CK_OST;
                else if (use_pll)
                begin
                    ck_next  = RSQ_CK_LOCK;
                    ckc_next = C_LOCK;
                end
                else if (use_fail_safe_clock_monitor)
                begin
                    ck_next  = RSQ_CK_FAIL_SAFE_CLOCK_MONITOR;
                    ckc_next = C_FAIL_SAFE_CLOCK_MONITOR;
                end
                else
                    ck_next = RSQ_CK_DONE;
            end
            RSQ_CK_OST:  if (osc_tick_i && (ost_reg == 10'h3ff))                // [RULE_09]
                         begin
                             ck_next  = use_pll ? RSQ_CK_LOCK : RSQ_CK_FAIL_SAFE_CLOCK_MONITOR;
                             ckc_next = use_pll ? C_LOCK : C_FAIL_SAFE_CLOCK_MONITOR;
                         end
            RSQ_CK_LOCK: if (ckc_done)                                          // [RULE_10]
                         begin
                             ck_next  = RSQ_CK_FAIL_SAFE_CLOCK_MONITOR;
                             ckc_next = C_FAIL_SAFE_CLOCK_MONITOR;
                         end
            RSQ_CK_FAIL_SAFE_CLOCK_MONITOR: if (ckc_done)
                             ck_next = RSQ_CK_DONE;                             // [RULE_15]
            RSQ_CK_DONE: ck_next = RSQ_CK_DONE;
            default:     ck_next = RSQ_CK_IDLE;
        endcase
        if (req)
            ck_next = RSQ_CK_IDLE;                                              // [RULE_11]
    end

    // ==========================================================
    // state registers
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cause_reg <= RSQ_CAUSE_POR;
            src_reg   <= RSQ_SRC_PLAIN;
            regen_reg <= 1'b1;
            st_reg    <= RSQ_ST_POR;
            cnt_reg   <= C_POR;
            ck_reg    <= RSQ_CK_DONE;
            ckc_reg   <= 25'h0000000;
        end
        else if (ce_i)
        begin
            if (req)
            begin
                cause_reg <= rst_req_i.cause;                                   // [RULE_18]
                src_reg   <= rst_req_i.src;
                regen_reg <= rst_req_i.reg_en;
            end
            st_reg  <= st_next;
            cnt_reg <= cnt_next;
            ck_reg  <= ck_next;
            ckc_reg <= ckc_next;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            ost_reg <= 10'h000;
        else if (ce_i)
        begin
            if (ck_reg != RSQ_CK_OST)
                ost_reg <= 10'h000;
            else if (osc_tick_i)
                ost_reg <= ost_reg + 10'h001;                                   // [RULE_09]
        end
    end

    // ==========================================================
    // monitor and fallback
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mon_reg <= 1'b0;
            frc_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (req)
                mon_reg <= 1'b0;
            else if (mon_start)
                mon_reg <= 1'b1;                                                // [RULE_13]
            if (fail_ev)
                frc_reg <= 1'b1;                                                // [RULE_14]
            else if (req)
                frc_reg <= 1'b0;
        end
    end

    // ==========================================================
    // register port and interrupt
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            stat_reg  <= 3'h0;
            mask_reg  <= 3'h0;
            rdata_reg <= 8'h00;
        end
        else if (ce_i)
        begin
            stat_reg  <= ev | (stat_reg & ~(wr_stat ? wdata_i[2:0] : 3'h0));
            if (wr_mask)
                mask_reg <= wdata_i[2:0];
            rdata_reg <= rd_i ? rd_mux : 8'h00;
        end
    end

    assign rdata_o       = rdata_reg;
    assign sys_rst_o     = (st_reg != RSQ_ST_RUN);
    assign sys_clk_en_o  = clk_rdy;
    assign exec_en_o     = !sys_rst_o && clk_rdy;                               // [RULE_12]
    assign fail_safe_clock_monitor_active_o = mon_reg;
    assign frc_switch_o  = frc_reg;
    assign irq_o         = |(stat_reg & mask_reg);

    // ==========================================================
    // checks
    property p_exec_gate;
        @(posedge clk_i) disable iff (rst_i)
        (sys_rst_o || ck_reg == RSQ_CK_IDLE || ck_reg == RSQ_CK_OST || ck_reg == RSQ_CK_LOCK)
            |-> !exec_en_o;
    endproperty
    a_exec_gate: assert property (p_exec_gate) else $error("exec without clock"); // [RULE_12]

    property p_other_rst;
        @(posedge clk_i) disable iff (rst_i)
        (req && rst_req_i.cause == RSQ_CAUSE_OTHER) |=> (st_reg == RSQ_ST_RST && cnt_reg == C_RST);
    endproperty
    a_other_rst: assert property (p_other_rst) else $error("other reset chain wrong"); // [RULE_07]

    property p_por_start;
        @(posedge clk_i) disable iff (rst_i)
        (req && rst_req_i.cause == RSQ_CAUSE_POR) |=> (st_reg == RSQ_ST_POR && cnt_reg == C_POR);
    endproperty
    a_por_start: assert property (p_por_start) else $error("power-on chain wrong"); // [RULE_01]

    property p_bor_start;
        @(posedge clk_i) disable iff (rst_i)
        (req && rst_req_i.cause == RSQ_CAUSE_BOR) |=> (st_reg == RSQ_ST_STARTUP);
    endproperty
    a_bor_start: assert property (p_bor_start) else $error("brown-out chain wrong"); // [RULE_06]

    property p_mon_late;
        @(posedge clk_i) disable iff (rst_i)
        $rose(mon_reg) |-> (!sys_rst_o && $past(ck_reg) == RSQ_CK_DONE);
    endproperty
    a_mon_late: assert property (p_mon_late) else $error("monitor started early"); // [RULE_15]

    property p_frc;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && fail_ev) |=> frc_switch_o;
    endproperty
    a_frc: assert property (p_frc) else $error("no fallback switch"); // [RULE_14]

    property p_no_ck_other;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && ck_reg == RSQ_CK_IDLE && !use_pll && !use_xtal && !use_fail_safe_clock_monitor && !req)
            |=> (ck_reg == RSQ_CK_DONE);
    endproperty
    a_no_ck_other: assert property (p_no_ck_other) else $error("clock delayed"); // [RULE_08]

    property p_ost_end;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !req && ck_reg == RSQ_CK_OST && osc_tick_i && ost_reg == 10'h3ff)
            |=> (ck_reg != RSQ_CK_OST);
    endproperty
    a_ost_end: assert property (p_ost_end) else $error("start-up timer overrun"); // [RULE_09]

    property p_wake_short;
        @(posedge clk_i) disable iff (rst_i)
        (req && rst_req_i.cause == RSQ_CAUSE_WAKE && !rst_req_i.reg_en)
            |=> (st_reg == RSQ_ST_RST && cnt_reg == C_RST);
    endproperty
    a_wake_short: assert property (p_wake_short) else $error("wake chain wrong"); // [RULE_04]

    property p_wake_long;
        @(posedge clk_i) disable iff (rst_i)
        (req && rst_req_i.cause == RSQ_CAUSE_WAKE && rst_req_i.reg_en)
            |=> (st_reg == RSQ_ST_STARTUP && cnt_reg == C_STRT);
    endproperty
    a_wake_long: assert property (p_wake_long) else $error("wake start-up missing"); // [RULE_04]

    property p_por_next;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !req && st_reg == RSQ_ST_POR && cnt_done)
            |=> (st_reg == RSQ_ST_STARTUP && cnt_reg == (regen_reg ? C_STRT : C_POWER_UP_TIMER));
    endproperty
    a_por_next: assert property (p_por_next) else $error("start-up delay wrong"); // [RULE_03]

    property p_rst_last;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !req && st_reg == RSQ_ST_STARTUP && cnt_done)
            |=> (st_reg == RSQ_ST_RST && cnt_reg == C_RST && sys_rst_o);
    endproperty
    a_rst_last: assert property (p_rst_last) else $error("state time missing"); // [RULE_05]

    property p_lock_entry;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !req && ck_reg == RSQ_CK_IDLE && use_pll && !use_xtal)
            |=> (ck_reg == RSQ_CK_LOCK && ckc_reg == C_LOCK);
    endproperty
    a_lock_entry: assert property (p_lock_entry) else $error("lock delay not loaded"); // [RULE_10]

    property p_fail_safe_clock_monitor_end;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && !req && ck_reg == RSQ_CK_FAIL_SAFE_CLOCK_MONITOR && ckc_done) |=> (ck_reg == RSQ_CK_DONE);
    endproperty
    a_fail_safe_clock_monitor_end: assert property (p_fail_safe_clock_monitor_end) else $error("monitor delay overrun"); // [RULE_16]

    property p_freeze;
        @(posedge clk_i) disable iff (rst_i)
        !ce_i |=> ($stable(st_reg) && $stable(cnt_reg) && $stable(ck_reg) && $stable(stat_reg));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // [RULE_17]
endmodule : rsq_sequencer

/* tb/rsq_far_side_model.sv */
// Purpose: oscillator and clock monitor standing beside the sequencer
// Assumes: one oscillator period is OSC_DIV system clocks
// Notes:   bad_clk_i makes the monitor see no valid clock
`timescale 1ns/100ps

module rsq_far_side_model #(
    parameter int OSC_DIV = 2
)(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic bad_clk_i,
    output logic      osc_tick_o,
    output logic      clk_valid_o
);
    // ==========================================================
    // oscillator period divider
    logic [3:0] div_reg;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            div_reg <= 4'h0;
        else
            div_reg <= (div_reg == 4'(OSC_DIV - 1)) ? 4'h0 : div_reg + 4'h1;
    end

    assign osc_tick_o  = (div_reg == 4'(OSC_DIV - 1));
    assign clk_valid_o = !bad_clk_i;
endmodule : rsq_far_side_model

/* tb/reset_startup_delay_sequencer_tb_top.sv */
// Purpose: self-checking bench for the reset start-up delay sequencer
// Assumes: delays shortened through the T_*_NS parameters
// Notes:   expected counts come from the integer model below
`timescale 1ns/100ps

module reset_startup_delay_sequencer_tb_top;
    import rsq_pkg::*;
    // ==========================================================
    // model constants, in cycles
    localparam int P_POR = 10, P_SU = 20, P_PW = 50, P_RST = 15;
    localparam int P_LK = 12, P_FS = 25, OSC = 2;

    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, fail_safe_clock_monitor_en_i = 1'b0, bad = 1'b0;
    logic wr_i = 1'b0, rd_i = 1'b0, osc_tick, clk_valid;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00, rdata_o, rv, rv2;
    logic sys_rst_o, sys_clk_en_o, exec_en_o, fail_safe_clock_monitor_active_o, frc_switch_o, irq_o;
    rsq_req_s req_r = '0;
    logic [31:0] seed = 32'h0680;
    int n_mismatch = 0, n_tests = 0, nh, nl;
    bit ok;

    always #2 clk_i = ~clk_i;

    rsq_sequencer #(.T_POR_NS(P_POR*4), .T_STARTUP_NS(P_SU*4), .T_POWER_UP_TIMER_NS(P_PW*4),
        .T_RST_NS(P_RST*4), .T_LOCK_NS(P_LK*4), .T_FAIL_SAFE_CLOCK_MONITOR_NS(P_FS*4)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .rst_req_i(req_r),
        .osc_tick_i(osc_tick), .fail_safe_clock_monitor_en_i(fail_safe_clock_monitor_en_i), .clk_valid_i(clk_valid),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sys_rst_o(sys_rst_o), .sys_clk_en_o(sys_clk_en_o), .exec_en_o(exec_en_o),
        .fail_safe_clock_monitor_active_o(fail_safe_clock_monitor_active_o), .frc_switch_o(frc_switch_o), .irq_o(irq_o));

    rsq_far_side_model #(.OSC_DIV(OSC)) far_u (.clk_i(clk_i), .rst_i(rst_i),
        .bad_clk_i(bad), .osc_tick_o(osc_tick), .clk_valid_o(clk_valid));

    // ==========================================================
    // model and helpers
    function automatic int rst_exp(input int c, input int r);
        int su;
        su = r ? P_SU : P_PW;
        case (c)
            0:       return P_POR + su + P_RST;
            1:       return su + P_RST;
            3:       return (r ? P_SU : 0) + P_RST;
            default: return P_RST;
        endcase
    endfunction : rst_exp

    function automatic int ck_exp(input int c, input int s);
        int e;
        e = 0;
        if (c > 1) return 0;
        if (s >= 2) e += 1024 * OSC;
        if (s[0]) e += P_LK;
        return e;
    endfunction : ck_exp

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction : lfsr_next

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", nm, ex, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        d = rdata_o;
    endtask : rd

    task automatic watch();
        int k;
        nh = 0;
        nl = 0;
        k = 0;
        ok = 1;
        @(posedge clk_i);
        do
        begin
            @(negedge clk_i);
            nh += int'(sys_rst_o);
            nl += int'(!sys_clk_en_o);
            if (exec_en_o !== 1'b0 && (sys_rst_o !== 1'b0 || sys_clk_en_o !== 1'b1)) ok = 0;
            k++;
        end while ((sys_rst_o !== 1'b0 || sys_clk_en_o !== 1'b1 || k < 3) && k < 6000);
    endtask : watch

    task automatic run(input int c, input int s, input int r, input int pre,
                       input int gap, input logic fen, input logic bd);
        int ec;
        ec = ck_exp(c, s);
        @(posedge clk_i);
        fail_safe_clock_monitor_en_i <= fen;
        bad <= bd;
        req_r <= '{req: 1'b1, cause: rsq_cause_e'(3'(c)), src: rsq_src_e'(3'(s)),
                   reg_en: 1'(r)};
        fork
            begin
                @(posedge clk_i);
                req_r.req <= 1'b0;
                if (pre > 0)
                begin
                    repeat (pre - 1) @(posedge clk_i);
                    req_r.req <= 1'b1;
                    @(posedge clk_i);
                    req_r.req <= 1'b0;
                end
                if (gap > 0)
                begin
                    ce_i <= 1'b0;
                    repeat (gap) @(posedge clk_i);
                    ce_i <= 1'b1;
                end
            end
            watch();
        join
        chk("rst_cycles", rst_exp(c, r) + pre + gap, nh);
        chk("clk_delay", 1, nl >= ec - 2 && nl <= ec + 2 * OSC + 2);
        chk("exec_gate", 1, ok);
        repeat (P_FS + 4) @(posedge clk_i);
        @(negedge clk_i);
        chk("frc_switch", fen & bd, frc_switch_o);
        if (bd === 1'b0) chk("monitor_on", fen, fail_safe_clock_monitor_active_o);
        chk("exec_en", 1, exec_en_o);
    endtask : run

    task automatic end_of_test();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // main sequence
    initial
    begin
        int ca[10] = '{0, 0, 0, 0, 1, 1, 3, 3, 2, 2};
        int sr[10] = '{0, 1, 2, 3, 3, 0, 0, 1, 2, 0};
        int rg[10] = '{1, 1, 0, 1, 0, 1, 0, 1, 1, 1};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        watch();
        chk("boot_rst", 1, nh >= P_POR + P_SU + P_RST - 2 && nh <= P_POR + P_SU + P_RST + 2);
        wr(4'h0, 8'h07);
        rd(4'h0, rv);
        chk("stat_clr", 8'h00, rv);
        for (int i = 0; i < 10; i++)
        begin
            seed = lfsr_next(seed);
            run(ca[i], sr[i], rg[i], (i == 8) ? 4 : 0, (i == 9) ? 5 : 0, seed[4], seed[5]);
        end
        wr(4'h0, 8'h07);
        run(2, 0, 1, 0, 0, 1'b1, 1'b1);
        rd(4'h0, rv);
        chk("stat", 8'h05, rv);
        rd(4'hf, rv);
        chk("unmapped", 8'h00, rv);
        wr(4'h1, 8'h04);
        @(negedge clk_i);
        chk("irq_on", 1, irq_o);
        wr(4'h0, 8'h04);
        @(negedge clk_i);
        chk("irq_off", 0, irq_o);
        rd(4'h0, rv);
        chk("stat_w1c", 8'h01, rv);
        wr(4'h1, 8'h01);
        @(negedge clk_i);
        chk("irq_rel", 1, irq_o);
        wr(4'h0, 8'h01);
        @(negedge clk_i);
        chk("irq_rel_off", 0, irq_o);
        rd(4'h2, rv);
        chk("info", 8'h93, rv);
        wr(4'h2, 8'hff);
        rd(4'h2, rv2);
        chk("info_ro", rv, rv2);
        end_of_test();
    end

    initial
    begin
        #160000;
        n_mismatch++;
        end_of_test();
    end
endmodule : reset_startup_delay_sequencer_tb_top
